// ### bench/pix_byte_sink.sv
`timescale 1ns/1ps
`default_nettype none
module pix_byte_sink (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // byte stream from the packer
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_data_i,
   input wire logic stall_i,
   output logic byte_ready_o
);
   logic [7:0] got[$]; // bytes taken, in arrival order
   logic tog_r; // alternates to throttle acceptance
   // half-rate toggle, used only while stalling
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tog_r <= 1'b0;
      end else begin
         tog_r <= ~tog_r;
      end
   end
   // a byte counts only where valid meets ready at an edge
   always @(posedge clk_i) begin
      if (!rst_i && byte_valid_i && byte_ready_o) begin
         got.push_back(byte_data_i);
      end
   end
   // stalling holds bytes for an extra cycle, exposing hold bugs
   assign byte_ready_o = !rst_i && (!stall_i || tog_r);
endmodule
`default_nettype wire

// ### bench/tb_mono_pixel_format_packer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mono_pixel_format_packer;
   import pix_pack_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic stall = 1'b0;
   logic pval = 1'b0;
   logic psof = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   logic [31:0] rdat;
   logic [11:0] pdat = 12'h000;
   logic ack, prdy, bval, brdy;
   logic [7:0] bdat, tag;
   logic [7:0] exp[$]; // expected byte stream of one frame
   logic [11:0] pv[4] = '{12'hfff, 12'h123, 12'h000, 12'ha5c};
   logic [7:0] tg[5] = '{TAG_MONO8, TAG_MONO12, TAG_PACK12, TAG_C422, TAG_L422};
   int n_errors = 0;
   int n_checks = 0;
   always #10 clk_i = ~clk_i;
   mono_pixel_format_packer mono_pixel_format_packer_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .pix_valid_i(pval),
      .pix_sof_i(psof), .pix_data_i(pdat), .pix_ready_o(prdy), .byte_valid_o(bval),
      .byte_data_o(bdat), .byte_ready_i(brdy), .leader_tag_o(tag));
   pix_byte_sink pix_byte_sink_i (.clk_i(clk_i), .rst_i(rst_i), .byte_valid_i(bval),
      .byte_data_i(bdat), .stall_i(stall), .byte_ready_o(brdy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, want, seen);
      end
   endtask
   // a wait that ran out ends the run
   task automatic tmo(input int k, input int lim);
      if (k >= lim) begin
         n_errors++;
         conclude();
      end
   endtask
   // classic single cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = rd;
      tmo(k, 20);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // valid stays up between pixels so it is never lowered and raised at once
   task automatic pix(input logic [11:0] d, input logic s);
      int k;
      pval <= 1'b1;
      psof <= s;
      pdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (prdy !== 1'b1 && k < 50);
      tmo(k, 50);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one frame; sw rewrites the layout after the first pixel
   task automatic frame(input logic [2:0] lay, input int n, input logic sw);
      int k;
      logic [11:0] p, q;
      exp.delete();
      pix_byte_sink_i.got.delete();
      bus(1'b1, REG_CTRL, 32'h10 | lay);
      for (int i = 0; i < n; i++) begin
         p = pv[i % 4];
         q = pv[(i + 3) % 4]; // even partner of an odd pixel
         case (lay)
            LAYOUT_MONO8: exp.push_back(p[11:4]);
            LAYOUT_GRAY16: begin
               exp.push_back(p[7:0]);
               exp.push_back({4'h0, p[11:8]});
            end
            LAYOUT_PACK12: begin
               if (i % 2 == 1) begin
                  exp.push_back({p[3:0], q[3:0]});
               end
               exp.push_back(p[11:4]);
            end
            LAYOUT_C422: begin
               exp.push_back(8'h00);
               exp.push_back(p[11:4]);
            end
            default: begin
               exp.push_back(p[11:4]);
               exp.push_back(8'h00);
            end
         endcase
         pix(p, i == 0);
         if (sw && i == 0) begin
            pval <= 1'b0;
            bus(1'b1, REG_CTRL, 32'h10 | LAYOUT_MONO8);
         end
      end
      pval <= 1'b0;
      k = 0;
      while (pix_byte_sink_i.got.size() < exp.size() && k < 300) begin
         @(posedge clk_i);
         k++;
      end
      tmo(k, 300);
      repeat (4) @(posedge clk_i);
      chk("count", pix_byte_sink_i.got.size(), exp.size());
      foreach (exp[j]) chk("byte", pix_byte_sink_i.got[j], exp[j]);
      chk("tag", tag, tg[lay]);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped", rdat, 32'h0);
      for (int l = 0; l < 5; l++) frame(l[2:0], 5, 1'b0);
      stall <= 1'b1;
      frame(LAYOUT_PACK12, 6, 1'b1);
      frame(LAYOUT_L422, 3, 1'b0);
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", rdat, 32'h14);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status", rdat, {20'h0, TAG_L422, 1'b0, LAYOUT_L422});
      bus(1'b0, REG_COUNT, 32'h0);
      chk("count_reg", rdat, 32'h7);
      conclude();
   end
endmodule
`default_nettype wire

// ### hw/mono_pixel_format_packer.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE1] layout chosen from layout select setting
// [RULE2] mono8: one brightness byte per pixel
// [RULE3] gray16: sixteen-bit word per pixel
// [RULE4] twelve bits low, upper four zero
// [RULE5] gray16 sends low byte then high
// [RULE6] gray16 word never above 0x0fff
// [RULE7] gray16 leader tag is mono12
// [RULE8] pack12: two pixels in three bytes
// [RULE9] bytes one/three hold pixel bits 11:4
// [RULE10] middle byte: odd low nibble high
// [RULE11] pack12 values unsigned up to 0x0fff
// [RULE12] 422 luma equals eight-bit brightness
// [RULE13] 422 chroma bytes always zero
// [RULE14] luma per pixel, chroma per pair
// [RULE15] two distinct 422 byte orders
// [RULE16] orders: U Y0 V Y1 / Y0 U Y1 V
// [RULE17] layout switches only at frame start
module mono_pixel_format_packer
   import pix_pack_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pixel input, pixel 12 bits msb aligned
   input wire logic pix_valid_i,
   input wire logic pix_sof_i,
   input wire logic [11:0] pix_data_i,
   output logic pix_ready_o,
   // byte output
   output logic byte_valid_o,
   output logic [7:0] byte_data_o,
   input wire logic byte_ready_i,
   // frame leader tag
   output logic [7:0] leader_tag_o
);
   ////////////////////////////////////////////////////////////////////////
   wb_req_t req;
   logic [31:0] ctrl_r; // software control word
   logic [2:0] layout_r; // layout in force for this frame
   logic [15:0] frames_r; // frames started
   logic [1:0] phase_r; // byte slot within group
   logic odd_r; // pixel parity within pair
   logic [11:0] even_r; // held even pixel
   logic [11:0] cur_r; // held current pixel
   logic busy_r; // bytes pending for held pixel
   logic [7:0] out_nxt;
   logic last_slot; // held pixel's final byte
   logic take; // pixel accepted
   logic [11:0] pix_clip; // clamped to range

   assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
   ////////////////////////////////////////////////////////////////////////
   // wishbone: ack one cycle after strobe, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
      end
   end

   // control write, byte-lane gated
   // lands at the edge where the master sees ack, never earlier
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= CTRL_RESET;
      end else if (req.cyc && req.stb && req.we && wb_ack_o && req.adr == REG_CTRL) begin
         for (int i = 0; i < 4; i++) begin
            if (req.sel[i]) begin
               ctrl_r[i*8 +: 8] <= req.dat[i*8 +: 8];
            end
         end
      end
   end

   // read mux; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else begin
         unique case (req.adr)
            REG_CTRL: wb_dat_o <= {27'h0, ctrl_r[CTRL_ENABLE_BIT], 1'b0, ctrl_r[2:0]};
            // status: tag, busy flag and active layout packed low
            REG_STATUS: wb_dat_o <= {20'h0, leader_tag_o, busy_r, layout_r};
            REG_COUNT: wb_dat_o <= {16'h0, frames_r};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // pixel accepted when enabled and nothing held; sof restarts parity
   assign pix_ready_o = !busy_r && ctrl_r[CTRL_ENABLE_BIT];
   assign take = pix_valid_i && pix_ready_o;
   // limits 12-bit data; already in range, kept explicit
   assign pix_clip = (pix_data_i > PIX_MAX) ? PIX_MAX : pix_data_i; // RULE6 RULE11

   // layout latched at start of frame only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         layout_r <= LAYOUT_MONO8;
         frames_r <= 16'h0;
      end else if (take && pix_sof_i) begin
         layout_r <= ctrl_r[CTRL_LAYOUT_LSB +: 3]; // RULE1 RULE17
         frames_r <= frames_r + 16'h1;
      end
   end

   // leader tag follows the frame's layout
   always_comb begin
      unique case (layout_r)
         LAYOUT_GRAY16: leader_tag_o = TAG_MONO12; // RULE7
         LAYOUT_PACK12: leader_tag_o = TAG_PACK12;
         LAYOUT_C422: leader_tag_o = TAG_C422;
         LAYOUT_L422: leader_tag_o = TAG_L422;
         default: leader_tag_o = TAG_MONO8;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // byte chooser per layout, slot and parity
   always_comb begin
      out_nxt = 8'h0;
      last_slot = 1'b1;
      unique case (layout_r)
         LAYOUT_GRAY16: begin
            // low byte first, upper nibble forced zero
            out_nxt = (phase_r == 2'd0) ? cur_r[7:0] : {4'h0, cur_r[11:8]}; // RULE3 RULE4 RULE5
            last_slot = (phase_r == 2'd1);
         end
         LAYOUT_PACK12: begin
            // even pixel: byte0 now; odd pixel: nibbles then msbs
            if (!odd_r) begin
               out_nxt = cur_r[11:4]; // RULE9
               last_slot = 1'b1;
            end else begin
               out_nxt = (phase_r == 2'd0) ? {cur_r[3:0], even_r[3:0]} : cur_r[11:4]; // RULE8 RULE10
               last_slot = (phase_r == 2'd1);
            end
         end
         LAYOUT_C422: begin
            // U Y0 | V Y1 ; chroma zero, one per pixel = pair per two
            out_nxt = (phase_r == 2'd0) ? 8'h00 : cur_r[11:4]; // RULE13 RULE16 RULE15
            last_slot = (phase_r == 2'd1); // RULE14
         end
         LAYOUT_L422: begin
            // Y0 U | Y1 V
            out_nxt = (phase_r == 2'd0) ? cur_r[11:4] : 8'h00; // RULE12 RULE16 RULE15
            last_slot = (phase_r == 2'd1); // RULE14
         end
         default: out_nxt = cur_r[11:4]; // RULE2
      endcase
   end

   // holding and byte sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
         phase_r <= 2'd0;
         odd_r <= 1'b0;
         cur_r <= 12'h0;
         even_r <= 12'h0;
      end else if (take) begin
         busy_r <= 1'b1;
         phase_r <= 2'd0;
         cur_r <= pix_clip;
         if (pix_sof_i) begin
            odd_r <= 1'b0;
         end
      end else if (busy_r && byte_ready_i) begin
         if (last_slot) begin
            busy_r <= 1'b0;
            if (!odd_r) begin
               even_r <= cur_r;
            end
            odd_r <= !odd_r;
         end else begin
            phase_r <= phase_r + 2'd1;
         end
      end
   end

   // byte valid registered, data muxed from held pixel; presented while pixel held
   assign byte_valid_o = busy_r;
   assign byte_data_o = out_nxt;

   ////////////////////////////////////////////////////////////////////////
   a_gray_high_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
      byte_valid_o && layout_r == LAYOUT_GRAY16 && phase_r == 2'd1 |-> byte_data_o[7:4] == 4'h0)
      else $error("gray16 high byte upper nibble not zero");
   a_gray_tag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      layout_r == LAYOUT_GRAY16 |-> leader_tag_o == TAG_MONO12)
      else $error("gray16 leader tag wrong");
   a_chroma_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      byte_valid_o && layout_r == LAYOUT_C422 && phase_r == 2'd0 |-> byte_data_o == 8'h00)
      else $error("chroma byte not zero");
   a_luma_first: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
      byte_valid_o && layout_r == LAYOUT_L422 && phase_r == 2'd0 |-> byte_data_o == cur_r[11:4])
      else $error("luma byte mismatch");
   a_layout_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
      !(take && pix_sof_i) |=> $stable(layout_r))
      else $error("layout changed mid frame");
   a_pack_mid: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      byte_valid_o && layout_r == LAYOUT_PACK12 && odd_r && phase_r == 2'd0
      |-> byte_data_o == {cur_r[3:0], even_r[3:0]})
      else $error("pack12 middle byte wrong");
   a_pack_msb: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
      byte_valid_o && layout_r == LAYOUT_PACK12 && !odd_r |-> byte_data_o == cur_r[11:4])
      else $error("pack12 even msb byte wrong");
   a_gray_low: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      take && layout_r == LAYOUT_GRAY16 && !pix_sof_i |=> byte_data_o == $past(pix_data_i[7:0]))
      else $error("gray16 low byte not first");

   // mono8 byte is the upper eight brightness bits
   a_mono8_byte: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
      byte_valid_o && layout_r == LAYOUT_MONO8 |-> byte_data_o == cur_r[11:4])
      else $error("mono8 byte wrong");

   // gray16 high byte keeps the word at or under the top code
   a_gray_word_max: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      byte_valid_o && layout_r == LAYOUT_GRAY16 && phase_r == 2'd1 |-> byte_data_o <= 8'h0f)
      else $error("gray16 word above top code");

   // gray16 first byte is the low brightness byte
   a_gray_low_byte: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
      byte_valid_o && layout_r == LAYOUT_GRAY16 && phase_r == 2'd0 |-> byte_data_o == cur_r[7:0])
      else $error("gray16 low byte wrong");

   // gray16 low byte taken leads to the high byte
   a_gray_two_bytes: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      byte_valid_o && layout_r == LAYOUT_GRAY16 && phase_r == 2'd0 && byte_ready_i
      |=> byte_valid_o && phase_r == 2'd1)
      else $error("gray16 high byte missing");

   // pack12 odd pixel closes the group with its upper bits
   a_pack_last: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
      byte_valid_o && layout_r == LAYOUT_PACK12 && odd_r && phase_r == 2'd1
      |-> byte_data_o == cur_r[11:4])
      else $error("pack12 third byte wrong");

   // pack12 even pixel gives a single byte
   a_pack_even_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      byte_valid_o && layout_r == LAYOUT_PACK12 && !odd_r && byte_ready_i |=> !byte_valid_o)
      else $error("pack12 even pixel gave extra bytes");

   // parity flips each time a held pixel completes
   a_pack_odd_flip: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      busy_r && byte_ready_i && last_slot |=> odd_r != $past(odd_r))
      else $error("pixel parity did not flip");

   // first pixel of a frame is always an even pixel
   a_sof_even: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      take && pix_sof_i |=> !odd_r)
      else $error("frame start not even");

   // chroma-first layout: second byte is luma
   a_c422_luma: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
      byte_valid_o && layout_r == LAYOUT_C422 && phase_r == 2'd1 |-> byte_data_o == cur_r[11:4])
      else $error("chroma-first luma wrong");

   // luma-first layout: second byte is chroma, always zero
   a_l422_chroma: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      byte_valid_o && layout_r == LAYOUT_L422 && phase_r == 2'd1 |-> byte_data_o == 8'h00)
      else $error("luma-first chroma not zero");

   // no new pixel accepted while bytes are pending
   a_ready_busy: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
      busy_r |-> !pix_ready_o)
      else $error("pixel accepted while busy");

   // an accepted pixel is presented the next cycle
   a_valid_after_take: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
      take |=> byte_valid_o)
      else $error("byte valid missing after take");

   // frame start latches the software layout select
   a_sof_latch: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
      take && pix_sof_i |=> layout_r == $past(ctrl_r[2:0]))
      else $error("layout not latched at frame start");

   // mono8 frames carry the mono8 tag
   a_tag_mono8: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
      layout_r == LAYOUT_MONO8 |-> leader_tag_o == TAG_MONO8)
      else $error("mono8 leader tag wrong");

   // the chroma-first 422 layout carries the chroma-first tag
   a_tag_422: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
      layout_r == LAYOUT_C422 |-> leader_tag_o == TAG_C422)
      else $error("chroma-first leader tag wrong");

   // ack is a single-cycle pulse
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
endmodule
`default_nettype wire

// ### inc/pix_pack_pkg.sv
package pix_pack_pkg;
   // output layout select codes
   localparam logic [2:0] LAYOUT_MONO8 = 3'h0;
   localparam logic [2:0] LAYOUT_GRAY16 = 3'h1;
   localparam logic [2:0] LAYOUT_PACK12 = 3'h2;
   localparam logic [2:0] LAYOUT_C422 = 3'h3;
   localparam logic [2:0] LAYOUT_L422 = 3'h4;
   // frame leader pixel-format tags (arbitrary codes)
   localparam logic [7:0] TAG_MONO8 = 8'h01;
   localparam logic [7:0] TAG_MONO12 = 8'h02;
   localparam logic [7:0] TAG_PACK12 = 8'h03;
   localparam logic [7:0] TAG_C422 = 8'h04;
   localparam logic [7:0] TAG_L422 = 8'h05;
   // register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_COUNT = 4'h8;
   // ctrl field positions and reset
   localparam int CTRL_LAYOUT_LSB = 0;
   localparam int CTRL_ENABLE_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [11:0] PIX_MAX = 12'hfff;
   // wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
endpackage
